// [eads_consts.vh]
// Purpose: constants for the external area decoder and boot strap block
// Assumes: included by bare name
// Notes: byte offsets on the register bus
`ifndef EADS_CONSTS_VH
`define EADS_CONSTS_VH
`define EADS_OFF_CMN      8'h00
`define EADS_OFF_RTCTRL   8'h04
`define EADS_OFF_REFRESH_TIMER_COUNTER    8'h08
`define EADS_OFF_RTCONST  8'h0C
`define EADS_OFF_STRAP    8'h10
`define EADS_OFF_DECODE   8'h14
`define EADS_OFF_SDMODE2  8'h18
`define EADS_OFF_SDMODE3  8'h1C
`define EADS_OFF_AREAW    8'h20
`define EADS_OFF_PROBE    8'h24
`define EADS_MAP_BIT      12
`define EADS_CMN_MASK     32'h00005E00
`define EADS_KEY          16'hA55A
`define EADS_AREA_MSB     28
`define EADS_AREA_LSB     26
`define EADS_HALF_BIT     25
`define EADS_W8           2'h1
`define EADS_W16          2'h2
`define EADS_W32          2'h3
`define EADS_RESP_OK      2'h0
`define EADS_RESP_ERR     2'h2
`endif

// [eads_strap_sync.v]
// Purpose: three-stage synchroniser with agreement filter for strap pins
// Assumes: pins are quasi-static
// Notes: first stage read only by the second
`timescale 1ns/1ns
`default_nettype none
module eads_strap_sync #(
    parameter WIDTH = 3
) (
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] pin_level
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    integer i;
    always @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
            stage3 <= {WIDTH{1'b0}};
            pin_level <= {WIDTH{1'b0}};
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2[i] == stage3[i]) begin
                    pin_level[i] <= stage3[i];
                end
            end
        end
    end
endmodule // eads_strap_sync
`default_nettype wire

// [eads_area_decode.v]
// Purpose: external area decoder, boot straps and keyed refresh registers
// Assumes: AXI4-Lite slave, one clock, synchronous active-low reset
// Notes: straps latched a fixed delay after reset release
`timescale 1ns/1ns
`default_nettype none
`include "eads_consts.vh"
module eads_area_decode #(
    parameter STRAP_SETTLE = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire width_strap_low,
    input wire width_strap_high,
    input wire endian_strap,
    input wire [31:0] phys_addr,
    output reg [2:0] area_num,
    output reg area_half_b,
    output reg use_half_b_ctrl,
    output reg byte_sel_allowed,
    output reg reserved_hit,
    output reg boot_select,
    output reg [1:0] area_width,
    output reg [1:0] boot_width,
    output reg little_endian,
    output reg strap_valid,
    output reg sdram_mode_wr,
    output reg sdram_mode_area3,
    output reg [15:0] sdram_mode_value
);
    ////////////////////////////////////////////////////////////////////////////
    reg [31:0] common_control_register;
    reg [15:0] refresh_timer_ctrl_status;
    reg [15:0] refresh_timer_counter;
    reg [15:0] refresh_time_constant;
    reg [13:0] area_width_cfg;
    reg [31:0] probe_addr;
    reg [7:0] aw_addr;
    reg aw_full;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_full;
    reg [3:0] settle_cnt;
    wire [2:0] strap_level;
    wire map2;
    wire wr_go;
    wire keyed_ok;
    wire [2:0] probe_area;

    function [2:0] area_of;
        input [31:0] addr;
        begin
            area_of = addr[`EADS_AREA_MSB:`EADS_AREA_LSB];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    eads_strap_sync #(
        .WIDTH(3)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({endian_strap, width_strap_high, width_strap_low}),
        .pin_level(strap_level)
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            settle_cnt <= 4'h0;
            strap_valid <= 1'b0;
            boot_width <= 2'h0;
            little_endian <= 1'b0;
        end else if (!strap_valid) begin
            if (settle_cnt == STRAP_SETTLE[3:0]) begin
                strap_valid <= 1'b1;
                boot_width <= strap_level[1:0];
                little_endian <= strap_level[2];
            end else begin
                settle_cnt <= settle_cnt + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign map2 = common_control_register[`EADS_MAP_BIT];

    always @* begin
        area_num = area_of(phys_addr);
        area_half_b = phys_addr[`EADS_HALF_BIT];
        reserved_hit = (area_num == 3'h7);
        boot_select = (area_num == 3'h0);
        use_half_b_ctrl = 1'b0;
        byte_sel_allowed = (area_num >= 3'h2) && (area_num <= 3'h4);
        if (area_num == 3'h5 || area_num == 3'h6) begin
            if (map2) begin
                use_half_b_ctrl = 1'b1;
                byte_sel_allowed = 1'b1;
            end else begin
                use_half_b_ctrl = area_half_b;
                byte_sel_allowed = area_half_b;
            end
        end
        if (boot_select) begin
            area_width = boot_width;
        end else if (reserved_hit || area_num == 3'h1) begin
            area_width = `EADS_W32;
        end else begin
            area_width = area_width_cfg[2*(area_num-3'h2) +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_full && w_full;
    assign keyed_ok = (w_strb == 4'hF) && (w_data[31:16] == `EADS_KEY);
    assign probe_area = area_of(probe_addr);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EADS_RESP_OK;
            common_control_register <= 32'h00000000;
            refresh_timer_ctrl_status <= 16'h0000;
            refresh_timer_counter <= 16'h0000;
            refresh_time_constant <= 16'h0000;
            area_width_cfg <= 14'h3FFF;
            probe_addr <= 32'h00000000;
            sdram_mode_wr <= 1'b0;
            sdram_mode_area3 <= 1'b0;
            sdram_mode_value <= 16'h0000;
        end else begin
            sdram_mode_wr <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `EADS_RESP_OK;
                case ({aw_addr[7:2], 2'b00})
                    `EADS_OFF_CMN: begin
                        common_control_register <= w_data & `EADS_CMN_MASK;
                    end
                    `EADS_OFF_RTCTRL: begin
                        if (keyed_ok) refresh_timer_ctrl_status <= w_data[15:0];
                    end
                    `EADS_OFF_REFRESH_TIMER_COUNTER: begin
                        if (keyed_ok) refresh_timer_counter <= w_data[15:0];
                    end
                    `EADS_OFF_RTCONST: begin
                        if (keyed_ok) refresh_time_constant <= w_data[15:0];
                    end
                    `EADS_OFF_SDMODE2, `EADS_OFF_SDMODE3: begin
                        sdram_mode_wr <= 1'b1;
                        sdram_mode_area3 <= aw_addr[2];
                        sdram_mode_value <= w_data[15:0];
                    end
                    `EADS_OFF_AREAW: begin
                        area_width_cfg <= w_data[13:0];
                    end
                    `EADS_OFF_PROBE: begin
                        probe_addr <= w_data;
                    end
                    `EADS_OFF_STRAP, `EADS_OFF_DECODE: begin
                        s_axi_bresp <= `EADS_RESP_OK;
                    end
                    default: begin
                        s_axi_bresp <= `EADS_RESP_ERR;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `EADS_RESP_OK;
        end else begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `EADS_RESP_OK;
                case ({s_axi_araddr[7:2], 2'b00})
                    `EADS_OFF_CMN: s_axi_rdata <= common_control_register;
                    `EADS_OFF_RTCTRL: s_axi_rdata <= {16'h0000, refresh_timer_ctrl_status};
                    `EADS_OFF_REFRESH_TIMER_COUNTER: s_axi_rdata <= {16'h0000, refresh_timer_counter};
                    `EADS_OFF_RTCONST: s_axi_rdata <= {16'h0000, refresh_time_constant};
                    `EADS_OFF_STRAP: s_axi_rdata <= {28'h0000000, strap_valid, little_endian,
                        boot_width};
                    `EADS_OFF_DECODE: s_axi_rdata <= {27'h0000000, probe_area == 3'h7,
                        (probe_area == 3'h5 || probe_area == 3'h6) &&
                        (map2 || probe_addr[`EADS_HALF_BIT]), probe_area};
                    `EADS_OFF_SDMODE2, `EADS_OFF_SDMODE3: s_axi_rdata <= 32'h00000000;
                    `EADS_OFF_AREAW: s_axi_rdata <= {18'h00000, area_width_cfg};
                    `EADS_OFF_PROBE: s_axi_rdata <= probe_addr;
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `EADS_RESP_ERR;
                    end
                endcase
            end
        end
    end
endmodule // eads_area_decode
`default_nettype wire

// [eads_area_decode_asserts.sv]
// Purpose: port checker for the external area decoder
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the decoder
`timescale 1ns/1ns
`default_nettype none
module eads_area_decode_chk #(
    parameter STRAP_SETTLE = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] phys_addr,
    input wire logic [2:0] area_num,
    input wire logic use_half_b_ctrl,
    input wire logic byte_sel_allowed,
    input wire logic reserved_hit,
    input wire logic boot_select,
    input wire logic [1:0] area_width,
    input wire logic [1:0] boot_width,
    input wire logic strap_valid,
    input wire logic sdram_mode_wr,
    input wire logic [15:0] sdram_mode_value
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence s_release;
    $rose(aresetn);
endsequence
sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
// low half of the data word as taken on the write data channel
logic [15:0] w_low;
always @(posedge aclk) begin
    if (s_axi_wvalid && s_axi_wready) w_low <= s_axi_wdata[15:0];
end
////////////////////////////////////////////////////////////////////////////////
a_area_from_addr: assert property (area_num == phys_addr[28:26])
    else $error("area number differs from address bits");
a_boot_area_sel: assert property (boot_select == (phys_addr[28:26] == 3'h0))
    else $error("boot select wrong");
a_reserved_decode: assert property (reserved_hit == (phys_addr[28:26] == 3'h7))
    else $error("reserved area flag wrong");
a_half_a_plain: assert property ((area_num inside {3'h5, 3'h6}) && !use_half_b_ctrl
    |-> !byte_sel_allowed) else $error("byte select allowed in half A");
a_boot_width_used: assert property (strap_valid && boot_select |-> area_width == boot_width)
    else $error("boot area width not from straps");
a_straps_hold: assert property (strap_valid |=> strap_valid && $stable(boot_width))
    else $error("strap latch changed");
a_strap_latency: assert property (s_release |-> !strap_valid ##[1:40] strap_valid)
    else $error("straps not latched in time");
a_mode_pulse: assert property (sdram_mode_wr |-> $rose(s_axi_bvalid) ##1 !sdram_mode_wr)
    else $error("mode write pulse misplaced");
a_mode_value: assert property (sdram_mode_wr |-> sdram_mode_value == w_low)
    else $error("mode value differs from written data");
a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule // eads_area_decode_chk
bind eads_area_decode eads_area_decode_chk #(.STRAP_SETTLE(STRAP_SETTLE)) chk_i (.*);
`default_nettype wire

// [eads_sdram_model.sv]
// Purpose: external memory side, keeps the mode registers of the SDRAM
// Assumes: mode write is a one-cycle pulse
// Notes: area 3 flag picks the register
`timescale 1ns/1ns
`default_nettype none
module eads_sdram_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mode_wr,
    input wire logic mode_area3,
    input wire logic [15:0] mode_value,
    output logic [15:0] mode2,
    output logic [15:0] mode3
);
always @(posedge aclk) begin
    if (!aresetn) begin
        mode2 <= 16'h0000;
        mode3 <= 16'h0000;
    end else if (mode_wr && mode_area3) begin
        mode3 <= mode_value;
    end else if (mode_wr) begin
        mode2 <= mode_value;
    end
end
endmodule // eads_sdram_model
`default_nettype wire

// [eads_area_decode_tb.sv]
// Purpose: self-checking bench for the external area decoder
// Assumes: straps set 16-bit, little endian before the first reset
// Notes: read results are compared by a monitor from a queue
`timescale 1ns/1ns
`default_nettype none
`include "eads_consts.vh"
module eads_area_decode_tb;
logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, area_half_b;
logic width_strap_low, width_strap_high, endian_strap, use_half_b_ctrl, byte_sel_allowed;
logic reserved_hit, boot_select, little_endian, strap_valid, sdram_mode_wr, sdram_mode_area3;
logic [1:0] s_axi_bresp, s_axi_rresp, area_width, boot_width;
logic [2:0] area_num;
logic [3:0] s_axi_wstrb;
logic [7:0] s_axi_awaddr, s_axi_araddr, off;
logic [15:0] sdram_mode_value, mode2, mode3;
logic [31:0] s_axi_wdata, s_axi_rdata, phys_addr, r;
logic [33:0] exp_q[$];
logic [1:0] bq[$];
logic [13:0] cfg;
int fails = 0;
int n_compared = 0;
eads_area_decode #(.STRAP_SETTLE(8)) eads_area_decode_i (.*);
eads_sdram_model eads_sdram_model_i (.aclk(aclk), .aresetn(aresetn), .mode_wr(sdram_mode_wr),
    .mode_area3(sdram_mode_area3), .mode_value(sdram_mode_value), .mode2(mode2), .mode3(mode3));
always #25 aclk = ~aclk;
////////////////////////////////////////////////////////////////////////////////
task check(input string what, input logic [33:0] e, input logic [33:0] got);
    n_compared++;
    if (got !== e) begin
        fails++;
        $display("unexpected %s expected %h seen %h", what, e, got);
    end
endtask
task test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ah, wh;
    ah = 0;
    wh = 0;
    @(posedge aclk);
    bq.push_back((a <= `EADS_OFF_PROBE) ? `EADS_RESP_OK : `EADS_RESP_ERR);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(ah && wh)) begin
        @(negedge aclk);
        ah = ah | (s_axi_awvalid & s_axi_awready);
        wh = wh | (s_axi_wvalid & s_axi_wready);
        @(posedge aclk);
        if (ah) s_axi_awvalid <= 1'b0;
        if (wh) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
endtask
task rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
endtask
task dec(input logic map, input logic [31:0] a);
    logic hb;
    logic [1:0] w;
    @(posedge aclk);
    phys_addr <= a;
    @(negedge aclk);
    hb = (a[28:26] == 3'h5 || a[28:26] == 3'h6) && (map || a[25]);
    w = (a[28:26] == 3'h0) ? `EADS_W16 : 2'h3;
    if (a[28:26] inside {[2:6]}) w = cfg[2 * (a[28:26] - 3'h2) +: 2];
    check("decode", {24'h0, w, a[25], a[28:26] == 3'h0, a[28:26], hb,
        hb || (a[28:26] inside {[2:4]}), a[28:26] == 3'h7},
        {24'h0, area_width, area_half_b, boot_select, area_num, use_half_b_ctrl,
        byte_sel_allowed, reserved_hit});
endtask
task restart(input logic [2:0] s);
    aresetn <= 1'b0;
    {width_strap_high, width_strap_low, endian_strap} <= s;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    do @(posedge aclk); while (strap_valid !== 1'b1);
    check("width", {32'h0, s[2:1]}, {32'h0, boot_width});
    check("endian", {33'h0, s[0]}, {33'h0, little_endian});
endtask
always @(posedge aclk) if (s_axi_rvalid && s_axi_rready)
    check("read", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
always @(posedge aclk) if (s_axi_bvalid && s_axi_bready)
    check("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    test_done;
end
////////////////////////////////////////////////////////////////////////////////
initial begin
    {aclk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, phys_addr} = 0;
    r = $urandom(32'hB273);
    restart(3'b101);
    rd(`EADS_OFF_STRAP, {30'h3, `EADS_W16});
    rd(`EADS_OFF_AREAW, 34'h3FFF);
    rd(8'h3C, {`EADS_RESP_ERR, 32'h0});
    wr(8'h3C, 32'h0, 4'hF);
    rd(`EADS_OFF_CMN, 34'h0);
    r = $urandom;
    cfg = r[13:0];
    wr(`EADS_OFF_AREAW, r, 4'hF);
    rd(`EADS_OFF_AREAW, {20'h0, cfg});
    for (int m = 0; m < 2; m++) begin
        for (int i = 0; i < 24; i++) dec(m[0], $urandom);
        dec(m[0], 32'hA4000000);
        r = ($urandom & 32'hE1FFFFFF) | 32'h14000000;
        wr(`EADS_OFF_PROBE, r, 4'hF);
        rd(`EADS_OFF_PROBE, {2'h0, r});
        rd(`EADS_OFF_DECODE, {30'h0, m[0], 3'h5});
        wr(`EADS_OFF_CMN, 32'h1000, 4'hF);
    end
    rd(`EADS_OFF_CMN, 34'h1000);
    for (off = `EADS_OFF_RTCTRL; off <= `EADS_OFF_RTCONST; off += 8'h04) begin
        r = $urandom;
        wr(off, {`EADS_KEY, r[15:0]}, 4'hF);
        wr(off, {16'h5AA5, ~r[15:0]}, 4'hF);
        wr(off, {`EADS_KEY, ~r[15:0]}, 4'h3);
        rd(off, {18'h0, r[15:0]});
    end
    restart(3'b010);
    restart(3'b110);
    rd(`EADS_OFF_STRAP, {30'h2, `EADS_W32});
    for (int k = 0; k < 2; k++) begin
        r = $urandom;
        wr(k ? `EADS_OFF_SDMODE3 : `EADS_OFF_SDMODE2, r, 4'hF);
        @(negedge aclk);
        check("mode", {18'h0, r[15:0]}, {18'h0, k ? mode3 : mode2});
    end
    rd(`EADS_OFF_SDMODE3, 34'h0);
    test_done;
end
endmodule // eads_area_decode_tb
`default_nettype wire
